// ==== include/lpbf_pkg.sv ====
// Constants and types shared by the pixel bus formatter files.
package lpbf_pkg;
    localparam int PIX_W = 24;
    localparam int BUS_W = 24;
    // Panel type codes.
    localparam logic [2:0] TYPE_YUV422 = 3'h0;
    localparam logic [2:0] TYPE_YUV444 = 3'h1;
    localparam logic [2:0] TYPE_DELTA_A = 3'h4;
    localparam logic [2:0] TYPE_DELTA_B = 3'h5;
    localparam logic [2:0] TYPE_HICOLOUR = 3'h6;
    localparam logic [2:0] TYPE_PROCESSOR = 3'h7;
    localparam logic [2:0] TYPE_RESET = TYPE_PROCESSOR;
    // Colour depth codes.
    localparam logic [1:0] DEPTH_4K = 2'h0;
    localparam logic [1:0] DEPTH_64K = 2'h1;
    localparam logic [1:0] DEPTH_256K = 2'h2;
    localparam logic [1:0] DEPTH_16M = 2'h3;
    // Component sequences, two bits per slot, first slot in the top bits (R=0, G=1, B=2).
    localparam logic [5:0] SEQ_RGB = 6'h06;
    localparam logic [5:0] SEQ_GBR = 6'h18;
    localparam logic [5:0] SEQ_BGR = 6'h24;
    localparam logic [5:0] SEQ_RBG = 6'h09;
    localparam logic [1:0] COMP_LAST = 2'h2;
    // Engine states.
    typedef enum logic [0:0] {
        ST_EMPTY  = 1'b0,
        ST_LOADED = 1'b1
    } lpbf_state_t;
endpackage

// ==== include/lpbf_stream_if.sv ====
// Valid/ready pixel stream between the formatter's own modules.
`timescale 1ns/1ps
interface lpbf_stream_if #(parameter int W = 24);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== design/lpbf_buffer.sv ====
// Two-entry pixel buffer with valid and ready on both sides.
`timescale 1ns/1ps
module lpbf_buffer #(
    parameter int W = 24
) (
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    lpbf_stream_if.snk  fill_s,
    lpbf_stream_if.src  drain_s
);
    import lpbf_pkg::*;

    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0]   count_reg, count_next;
    logic         push, pop;

    // Full stalls the source, so a slow panel never drops a pixel.
    assign fill_s.ready  = (count_reg != 2'h2);
    assign drain_s.valid = (count_reg != 2'h0);
    assign drain_s.data  = mem_reg[rd_reg];
    assign push = fill_s.valid && fill_s.ready;
    assign pop  = drain_s.valid && drain_s.ready;

    // Pointer, count and storage updates.
    always_comb begin
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_reg] = fill_s.data;
            wr_next = ~wr_reg;
        end
        if (pop) begin
            rd_next = ~rd_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // Storage carries no reset; only the pointers and the count need a defined start.
    always_ff @(posedge core_clk) begin
        mem_reg <= mem_next;
        if (sys_rst) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            count_reg <= count_next;
        end
    end
endmodule

// ==== design/lpbf_formatter.sv ====
// Panel data bus formatter: turns display FIFO pixels into panel bus transfers.
// Summary of operation
// - Packed YUV: output order field picks UYVY, YUYV, VYUY or YVYU.
// - Delta panel, full word, both bits clear: one rotating component per pixel.
// - Same with high bit set: two components even pixel, one odd pixel.
// - Delta panel, half word: two cycles per pixel, three when low bit set.
// - High-colour 16M on 8 bits: three bytes, plus dummy byte if high bit.
// - 64K on 8 bits or 256K on 9 bits: low bit picks which half first.
// - Processor panel 4096 colours, 16 bits: high bit picks upper or lower alignment.
// - Processor 12-bit on 8 bits: three transfers per two pixels; others per table.
// - 18-bit on 8-bit processor bus: three transfers, padded or packed.
// - 18-bit on 16 bits: two transfers, four arrangements; 9 bits two, 18 bits one.
// - Delta 24-bit: line order field picks the starting component per line.
// - High-colour 24-bit: one transfer on 24 bits, B G R bytes on 8 bits.
// - Panel type codes: YUV422, YUV444, two delta, high-colour, processor panel.
// - Colour depth codes: 4096, 65536, 262144, 16777216 colours.
`timescale 1ns/1ps
module lpbf_formatter #(
    parameter int PW = lpbf_pkg::PIX_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic [2:0]               panel_type,
    input  wire logic [1:0]               colour_depth_select,
    input  wire logic                     full_word_bus_width,
    input  wire logic [1:0]               output_order_select,
    input  wire logic                     bus_mode_18bit_panel,
    input  wire logic [1:0]               arrangement_18bit_panel,
    input  wire logic                     line_order_high,
    input  wire logic                     line_order_low,
    input  wire logic                     display_enable,
    input  wire logic                     line_start,
    input  wire logic                     line_is_even,
    input  wire logic                     pixel_clk_in,
    input  wire logic                     pix_valid,
    input  wire logic [PW-1:0]            pix_data,
    output logic                          pix_ready,
    output logic [lpbf_pkg::BUS_W-1:0]    panel_data_bus,
    output logic                          beat_strobe,
    output logic                          underrun
);
    import lpbf_pkg::*;

    lpbf_stream_if #(.W(PW)) fill_if ();
    lpbf_stream_if #(.W(PW)) drain_if ();

    assign fill_if.valid = pix_valid;
    assign fill_if.data  = pix_data;
    assign pix_ready     = fill_if.ready;

    lpbf_buffer #(.W(PW)) u_buffer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .fill_s   (fill_if),
        .drain_s  (drain_if)
    );

    // The pixel clock is foreign: two flops, then an edge finder on the second.
    logic lclk_s1_reg, lclk_s2_reg, lclk_s3_reg;
    logic link_edge;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lclk_s1_reg <= 1'b0;
            lclk_s2_reg <= 1'b0;
            lclk_s3_reg <= 1'b0;
        end else begin
            lclk_s1_reg <= pixel_clk_in;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
        end
    end
    assign link_edge = lclk_s2_reg && !lclk_s3_reg;

    lpbf_state_t       state_reg, state_next;
    logic [PW-1:0]     cur_reg, cur_next, prev_reg, prev_next;
    logic [1:0]        step_reg, step_next, k_reg, k_next;
    logic              odd_reg, odd_next, strobe_reg, strobe_next, under_reg, under_next;
    logic [BUS_W-1:0]  data_reg, data_next, beat_c;
    logic [2:0]        beats_c;
    logic              beat_go, is_delta, last_beat;
    logic [7:0]        cr, cg, cb, pb;
    logic [7:0]        y0, y1;
    logic [15:0]       p565;
    logic [17:0]       p666;
    logic [11:0]       p444;

    // Pick one colour byte by component code.
    function automatic logic [7:0] comp8(input logic [PW-1:0] p, input logic [1:0] c);
        comp8 = (c == 2'h0) ? p[23:16] : (c == 2'h1) ? p[15:8] : p[7:0];
    endfunction

    // Component for slot k of the line, from the line order field and line parity.
    function automatic logic [1:0] delta_comp(input logic hi, input logic lo, input logic even,
                                               input logic [1:0] k);
        logic [5:0] seq;
        case ({hi, lo})
            2'h0: seq = even ? SEQ_GBR : SEQ_RGB;
            2'h1: seq = even ? SEQ_RBG : SEQ_BGR;
            2'h2: seq = even ? SEQ_RGB : SEQ_GBR;
            default: seq = even ? SEQ_BGR : SEQ_RBG;
        endcase
        delta_comp = 2'((seq >> (3'h4 - {k, 1'b0})) & 6'h03);
    endfunction

    assign cr = cur_reg[23:16];
    assign cg = cur_reg[15:8];
    assign cb = cur_reg[7:0];
    assign pb = prev_reg[7:0];
    assign p565 = {cr[7:3], cg[7:2], cb[7:3]};
    assign p666 = {cr[7:2], cg[7:2], cb[7:2]};
    assign p444 = {cr[7:4], cg[7:4], cb[7:4]};
    assign is_delta = (panel_type == TYPE_DELTA_A) || (panel_type == TYPE_DELTA_B);

    // Transfers per pixel for the current settings and pixel parity.
    always_comb begin
        beats_c = 3'h1;
        case (panel_type)
            TYPE_YUV422: beats_c = full_word_bus_width ? 3'h1 : 3'h2;
            TYPE_YUV444: beats_c = full_word_bus_width ? 3'h1 : 3'h3;
            TYPE_DELTA_A, TYPE_DELTA_B: begin
                if (full_word_bus_width) begin
                    beats_c = (output_order_select[1] && !odd_reg) ? 3'h2 : 3'h1;
                end else begin
                    beats_c = output_order_select[0] ? 3'h3 : 3'h2;
                end
            end
            TYPE_HICOLOUR: begin
                if (colour_depth_select == DEPTH_16M && !full_word_bus_width) begin
                    beats_c = output_order_select[1] ? 3'h4 : 3'h3;
                end else if (colour_depth_select != DEPTH_4K && !full_word_bus_width) begin
                    beats_c = 3'h2;
                end
            end
            TYPE_PROCESSOR: begin
                case (colour_depth_select)
                    DEPTH_4K: beats_c = (!full_word_bus_width && odd_reg) ? 3'h2 : 3'h1;
                    DEPTH_64K: beats_c = full_word_bus_width ? 3'h1 : 3'h2;
                    DEPTH_256K: beats_c = (bus_mode_18bit_panel && !full_word_bus_width) ?
                                          3'h3 : (!bus_mode_18bit_panel && full_word_bus_width) ?
                                          3'h1 : 3'h2;
                    default: beats_c = 3'h1;
                endcase
            end
            default: beats_c = 3'h1;
        endcase
    end

    // Chroma pairing for packed YUV: Y in the top byte, then U, then V.
    always_comb begin
        case (output_order_select)
            2'h0: begin
                y0 = odd_reg ? cb : cg;
                y1 = cr;
            end
            2'h1: begin
                y0 = cr;
                y1 = odd_reg ? cb : cg;
            end
            2'h2: begin
                y0 = odd_reg ? cg : cb;
                y1 = cr;
            end
            default: begin
                y0 = cr;
                y1 = odd_reg ? cg : cb;
            end
        endcase
    end

    // Bus word for the current step of the current pixel.
    always_comb begin
        beat_c = '0;
        case (panel_type)
            TYPE_YUV422: beat_c = full_word_bus_width ? {8'h00, y0, y1} :
                                  {16'h0000, (step_reg == 2'h0) ? y0 : y1};
            TYPE_YUV444: beat_c = full_word_bus_width ? cur_reg :
                                  {16'h0000, comp8(cur_reg, step_reg)};
            TYPE_DELTA_A, TYPE_DELTA_B:
                beat_c = {16'h0000, comp8(cur_reg, delta_comp(line_order_high, line_order_low,
                                                               line_is_even, k_reg))};
            TYPE_HICOLOUR, TYPE_PROCESSOR: begin
                case (colour_depth_select)
                    DEPTH_16M: begin
                        if (full_word_bus_width || panel_type == TYPE_PROCESSOR) begin
                            beat_c = cur_reg;
                        end else if (step_reg != 2'h3) begin
                            beat_c = {16'h0000, comp8(cur_reg, COMP_LAST - step_reg)};
                        end
                    end
                    DEPTH_64K: begin
                        if (full_word_bus_width) begin
                            beat_c = {8'h00, p565};
                        end else if ((step_reg == 2'h0) != output_order_select[0]) begin
                            beat_c = {16'h0000, p565[15:8]};
                        end else begin
                            beat_c = {16'h0000, p565[7:0]};
                        end
                    end
                    DEPTH_256K: begin
                        if (full_word_bus_width && !bus_mode_18bit_panel) begin
                            beat_c = {6'h00, p666};
                        end else if (full_word_bus_width) begin
                            case ({arrangement_18bit_panel, step_reg[0]})
                                3'h0: beat_c = {8'h00, p666[17:2]};
                                3'h1: beat_c = {22'h000000, p666[1:0]};
                                3'h2: beat_c = {22'h000000, p666[17:16]};
                                3'h3: beat_c = {8'h00, p666[15:0]};
                                3'h4, 3'h6: beat_c = {8'h00, cr[7:2], 2'h0, cg[7:2], 2'h0};
                                3'h5: beat_c = {16'h0000, cb[7:2], 2'h0};
                                default: beat_c = {8'h00, cb[7:2], 10'h000};
                            endcase
                        end else if (bus_mode_18bit_panel && !arrangement_18bit_panel[0]) begin
                            beat_c = {16'h0000, comp8(cur_reg, step_reg)} & 24'h0000FC;
                        end else if (bus_mode_18bit_panel) begin
                            case (step_reg)
                                2'h0: beat_c = {16'h0000, p666[17:10]};
                                2'h1: beat_c = {16'h0000, p666[9:2]};
                                default: beat_c = {22'h000000, p666[1:0]};
                            endcase
                        end else if ((step_reg == 2'h0) != output_order_select[0]) begin
                            beat_c = {15'h0000, p666[17:9]};
                        end else begin
                            beat_c = {15'h0000, p666[8:0]};
                        end
                    end
                    default: begin
                        if (full_word_bus_width) begin
                            beat_c = output_order_select[1] ? {12'h000, p444} :
                                     {8'h00, p444, 4'h0};
                        end else if (!odd_reg) begin
                            beat_c = {16'h0000, p444[11:4]};
                        end else if (step_reg == 2'h0) begin
                            beat_c = {16'h0000, pb[7:4], p444[11:8]};
                        end else begin
                            beat_c = {16'h0000, p444[7:0]};
                        end
                    end
                endcase
            end
            default: beat_c = '0;
        endcase
    end

    // Settings are sampled live, so the sync engine must only change them while stopped.
    assign beat_go   = (state_reg == ST_LOADED) && link_edge && display_enable;
    assign last_beat = ({1'b0, step_reg} == beats_c - 3'h1);
    assign drain_if.ready = (state_reg == ST_EMPTY);

    // Load a pixel, emit one transfer per link edge, release the pixel after its last.
    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        prev_next = prev_reg;
        step_next = step_reg;
        k_next = k_reg;
        odd_next = odd_reg;
        data_next = data_reg;
        strobe_next = 1'b0;
        under_next = link_edge && display_enable && (state_reg == ST_EMPTY);
        if (state_reg == ST_EMPTY && drain_if.valid) begin
            cur_next = drain_if.data;
            step_next = 2'h0;
            state_next = ST_LOADED;
        end else if (beat_go) begin
            data_next = beat_c;
            strobe_next = 1'b1;
            k_next = (k_reg == COMP_LAST) ? 2'h0 : k_reg + 2'h1;
            step_next = step_reg + 2'h1;
            if (last_beat) begin
                prev_next = cur_reg;
                odd_next = ~odd_reg;
                state_next = ST_EMPTY;
            end
        end
        // A new line restarts the component rotation and pixel parity.
        if (line_start) begin
            k_next = 2'h0;
            odd_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_EMPTY;
            cur_reg <= '0;
            prev_reg <= '0;
            step_reg <= 2'h0;
            k_reg <= 2'h0;
            odd_reg <= 1'b0;
            data_reg <= '0;
            strobe_reg <= 1'b0;
            under_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            prev_reg <= prev_next;
            step_reg <= step_next;
            k_reg <= k_next;
            odd_reg <= odd_next;
            data_reg <= data_next;
            strobe_reg <= strobe_next;
            under_reg <= under_next;
        end
    end

    assign panel_data_bus = data_reg;
    assign beat_strobe = strobe_reg;
    assign underrun = under_reg;

    // Checks on the formatting engine.
    default clocking cb_core @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic ls_done;
    assign ls_done = (state_reg == ST_EMPTY);
    property p_yuyv_first_luma;
        beat_go && panel_type == TYPE_YUV422 && !full_word_bus_width &&
        output_order_select == 2'h1 && step_reg == 2'h0 |=> data_reg[7:0] == $past(cr);
    endproperty
    a_yuyv_first_luma: assert property (p_yuyv_first_luma) else $error("YUYV order wrong");
    property p_delta_one_per_pixel;
        beat_go && is_delta && full_word_bus_width && output_order_select == 2'h0
        |=> ls_done;
    endproperty
    a_delta_one_per_pixel: assert property (p_delta_one_per_pixel)
        else $error("1/3 mode not 1");
    property p_delta_half_even;
        beat_go && is_delta && full_word_bus_width && output_order_select == 2'h2 && !odd_reg &&
        step_reg == 2'h0 |=> !ls_done && step_reg == 2'h1;
    endproperty
    a_delta_half_even: assert property (p_delta_half_even)
        else $error("1/2 even pixel short");
    property p_delta_three_cycles;
        beat_go && is_delta && !full_word_bus_width && output_order_select == 2'h1 &&
        step_reg == 2'h1 |=> !ls_done;
    endproperty
    a_delta_three_cycles: assert property (p_delta_three_cycles)
        else $error("3-cycle early");
    property p_dummy_byte;
        beat_go && panel_type == TYPE_HICOLOUR && colour_depth_select == DEPTH_16M &&
        !full_word_bus_width && output_order_select[1] && step_reg == 2'h3
        |=> data_reg == '0 && ls_done;
    endproperty
    a_dummy_byte: assert property (p_dummy_byte) else $error("Dummy byte wrong");
    property p_high_byte_first;
        beat_go && panel_type == TYPE_PROCESSOR && colour_depth_select == DEPTH_64K &&
        !full_word_bus_width && output_order_select == 2'h0 && step_reg == 2'h0
        |=> data_reg[7:3] == $past(cr[7:3]);
    endproperty
    a_high_byte_first: assert property (p_high_byte_first)
        else $error("High byte not first");
    property p_4k_low_align;
        beat_go && panel_type == TYPE_PROCESSOR && colour_depth_select == DEPTH_4K &&
        full_word_bus_width && output_order_select[1]
        |=> data_reg[15:12] == 4'h0 && data_reg[11:8] == $past(cr[7:4]);
    endproperty
    a_4k_low_align: assert property (p_4k_low_align) else $error("4096 alignment wrong");
    property p_12bit_even_single;
        beat_go && panel_type == TYPE_PROCESSOR && colour_depth_select == DEPTH_4K &&
        !full_word_bus_width && !odd_reg |=> ls_done && odd_reg;
    endproperty
    a_12bit_even_single: assert property (p_12bit_even_single)
        else $error("12-bit pack wrong");
    property p_padded_bytes;
        beat_go && panel_type == TYPE_PROCESSOR && colour_depth_select == DEPTH_256K &&
        !full_word_bus_width && bus_mode_18bit_panel && !arrangement_18bit_panel[0] &&
        step_reg == 2'h0 |=> data_reg[1:0] == 2'h0 && data_reg[7:2] == $past(cr[7:2]);
    endproperty
    a_padded_bytes: assert property (p_padded_bytes) else $error("Padded byte wrong");
    property p_line_restart;
        line_start |=> k_reg == 2'h0 && !odd_reg;
    endproperty
    a_line_restart: assert property (p_line_restart) else $error("Line restart missed");
    property p_wide_pixel;
        beat_go && panel_type == TYPE_HICOLOUR && colour_depth_select == DEPTH_16M &&
        full_word_bus_width |=> data_reg == $past(cur_reg) && ls_done;
    endproperty
    a_wide_pixel: assert property (p_wide_pixel) else $error("24-bit pixel wrong");
    c_underrun: cover property (underrun);
    c_dummy_mode: cover property (beat_go && panel_type == TYPE_HICOLOUR && step_reg == 2'h3);
    c_delta_half: cover property (beat_go && is_delta && output_order_select == 2'h2 ##[1:40]
                                  beat_go && odd_reg);
endmodule

// ==== tb/lpbf_panel_model.sv ====
// Panel-side model that supplies the link clock for the formatter bench.
`timescale 1ns/1ps
module lpbf_panel_model (
    input  wire logic run,
    output logic      link_clk
);
    // The phase is kept unrelated to the core clock on purpose.
    // The clock stands low between frames, so no stray edge can pull a transfer.
    initial begin
        link_clk = 1'b0;
        #137;
        forever begin
            if (run) begin
                #400 link_clk = 1'b1;
                #400 link_clk = 1'b0;
            end else begin
                #50;
            end
        end
    end
endmodule

// ==== tb/lpbf_formatter_tb.sv ====
// Self-checking bench for the panel data bus formatter.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module lpbf_formatter_tb;
    import lpbf_pkg::*;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  panel_type = TYPE_RESET;
    logic [1:0]  colour_depth_select = DEPTH_16M;
    logic        full_word_bus_width = 1'b0;
    logic [1:0]  output_order_select = 2'h0;
    logic        line_order_low = 1'b0;
    logic        display_enable = 1'b0;
    logic        line_start = 1'b0;
    logic        pix_valid = 1'b0;
    logic [23:0] pix_data = 24'h0;
    logic        run = 1'b0;
    logic        pixel_clk_in;
    logic        pix_ready;
    logic        beat_strobe;
    logic        underrun;
    logic        under_seen = 1'b0;
    logic [23:0] panel_data_bus;
    logic [23:0] msk = 24'hFF;
    logic [23:0] px[$];
    logic [23:0] ex[$];
    int          error_cnt = 0;
    int          comparisons = 0;

    // The 100 ns core clock.
    always #50 core_clk = ~core_clk;

    lpbf_panel_model panel (.run(run), .link_clk(pixel_clk_in));

    lpbf_formatter dut (.core_clk(core_clk), .sys_rst(sys_rst), .panel_type(panel_type),
        .colour_depth_select(colour_depth_select), .full_word_bus_width(full_word_bus_width),
        .output_order_select(output_order_select), .bus_mode_18bit_panel(1'b0),
        .arrangement_18bit_panel(2'h0), .line_order_high(1'b0), .line_order_low(line_order_low),
        .display_enable(display_enable), .line_start(line_start), .line_is_even(1'b0),
        .pixel_clk_in(pixel_clk_in), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .panel_data_bus(panel_data_bus), .beat_strobe(beat_strobe),
        .underrun(underrun));

    // Any underrun while lines are fed means the buffer starved the link.
    always @(posedge core_clk) begin
        if (underrun === 1'b1) under_seen <= 1'b1;
    end

    // Component k of test pixel i, with R, G and B in distinct ranges.
    function automatic logic [7:0] comp(input int i, input int k);
        return 8'(8'hA0 + 8'h10 * k + i);
    endfunction

    function automatic logic [23:0] pix(input int i);
        return {comp(i, 0), comp(i, 1), comp(i, 2)};
    endfunction

    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Settings change only while the link is stopped, so no frame mixes formats.
    task automatic cfg(input logic [2:0] t, input logic fw, input logic [1:0] o,
                       input logic [23:0] m);
        @(posedge core_clk);
        panel_type <= t;
        full_word_bus_width <= fw;
        output_order_select <= o;
        msk <= m;
    endtask

    // Queues pixels and beats; a beat code is 4 * pixel + component, and 3 marks a dummy.
    task automatic load(input int np, input int n, input int c[8]);
        for (int i = 0; i < np; i++) px.push_back(pix(i));
        for (int j = 0; j < n; j++) begin
            ex.push_back(c[j] % 4 == 3 ? 'x : 24'(comp(c[j] / 4, c[j] % 4)));
        end
    endtask

    // Offers each pixel and holds it until an edge where ready is high.
    task automatic feed();
        int n;
        foreach (px[i]) begin
            pix_valid <= 1'b1;
            pix_data <= px[i];
            n = 0;
            do begin @(negedge core_clk); n++; end while (pix_ready !== 1'b1 && n < 200);
            if (n >= 200) begin error_cnt++; print_verdict(); end
            @(posedge core_clk);
        end
        pix_valid <= 1'b0;
    endtask

    // Each strobe lasts one cycle, so it is looked at on the falling edge inside it.
    task automatic collect();
        int n;
        foreach (ex[i]) begin
            n = 0;
            do begin @(negedge core_clk); n++; end while (beat_strobe !== 1'b1 && n < 40);
            if (n >= 40) begin error_cnt++; print_verdict(); end
            if (ex[i] !== 'x) `CHK(panel_data_bus & msk, ex[i])
        end
    endtask

    task automatic stream(input string name);
        line_start <= 1'b1;
        @(posedge core_clk);
        line_start <= 1'b0;
        run <= 1'b1;
        display_enable <= 1'b1;
        fork feed(); collect(); join
        `CHK(under_seen, 1'b0)
        @(posedge core_clk);
        run <= 1'b0;
        display_enable <= 1'b0;
        repeat (12) @(posedge core_clk);
        $display("Test %s done", name);
        px.delete();
        ex.delete();
    endtask

    // Two pixels share chroma, so each order code gives one exact byte sequence.
    task automatic t_yuv();
        logic [31:0] tab [4] = '{32'h22113344, 32'h11224433, 32'h33112244, 32'h11334422};
        for (int o = 0; o < 4; o++) begin
            cfg(TYPE_YUV422, 1'b0, 2'(o), 24'hFF);
            px = '{24'h112233, 24'h442233};
            for (int b = 3; b >= 0; b--) ex.push_back(24'(tab[o][8*b +: 8]));
            stream("yuv order");
        end
    endtask

    task automatic t_delta();
        cfg(TYPE_DELTA_A, 1'b1, 2'h0, 24'hFF);
        load(3, 3, '{0, 5, 10, 0, 0, 0, 0, 0});
        stream("delta one per pixel");
        line_order_low <= 1'b1;
        load(3, 3, '{2, 5, 8, 0, 0, 0, 0, 0});
        stream("delta line order");
        line_order_low <= 1'b0;
        cfg(TYPE_DELTA_A, 1'b1, 2'h2, 24'hFF);
        load(4, 6, '{0, 1, 6, 8, 9, 14, 0, 0});
        stream("delta one and a half");
        cfg(TYPE_DELTA_A, 1'b0, 2'h0, 24'hFF);
        load(3, 6, '{0, 1, 6, 4, 9, 10, 0, 0});
        stream("delta two cycle");
        cfg(TYPE_DELTA_A, 1'b0, 2'h1, 24'hFF);
        load(2, 6, '{0, 1, 2, 4, 5, 6, 0, 0});
        stream("delta three cycle");
    endtask

    task automatic t_hicolour();
        cfg(TYPE_HICOLOUR, 1'b0, 2'h0, 24'hFF);
        load(2, 6, '{2, 1, 0, 6, 5, 4, 0, 0});
        stream("high colour bytes");
        cfg(TYPE_HICOLOUR, 1'b0, 2'h2, 24'hFF);
        load(2, 8, '{2, 1, 0, 3, 6, 5, 4, 7});
        stream("high colour dummy");
        cfg(TYPE_HICOLOUR, 1'b1, 2'h0, 24'hFFFFFF);
        load(2, 0, '{0, 0, 0, 0, 0, 0, 0, 0});
        ex = '{pix(0), pix(1)};
        stream("full width");
    endtask

    // Processor panel: 4096 colours aligned low, 12-bit packing, 565 high byte first.
    task automatic t_processor();
        colour_depth_select <= DEPTH_4K;
        cfg(TYPE_PROCESSOR, 1'b1, 2'h2, 24'hFFFFFF);
        px = '{pix(0)};
        ex = '{24'h000ABC};
        stream("processor 4096 low");
        cfg(TYPE_PROCESSOR, 1'b0, 2'h0, 24'hFF);
        px = '{pix(0), pix(1)};
        ex = '{24'hAB, 24'hCA, 24'hBC};
        stream("processor 12-bit pack");
        colour_depth_select <= DEPTH_64K;
        cfg(TYPE_PROCESSOR, 1'b0, 2'h0, 24'hFF);
        px = '{pix(0)};
        ex = '{24'hA5, 24'h98};
        stream("processor 565 order");
    endtask

    // Reset is held for six edges before any pixel is offered.
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_yuv();
        t_delta();
        t_hicolour();
        t_processor();
        print_verdict();
    end
endmodule
